//--- verilog/cpcir_regs.vh
`ifndef CPCIR_REGS_VH
`define CPCIR_REGS_VH
// Register offsets.
`define CPCIR_OFS_PULL    4'h0
`define CPCIR_OFS_DRIVE   4'h1
`define CPCIR_OFS_STRETCH 4'h2
`define CPCIR_OFS_RSVD    4'h3
`define CPCIR_OFS_EXTINT  4'h4
`define CPCIR_OFS_ISTAT   4'h5
`define CPCIR_OFS_IMASK   4'h6
// Bit positions shared by pull and drive registers.
`define CPCIR_BIT_K       7
`define CPCIR_BIT_E       4
`define CPCIR_BIT_B       1
`define CPCIR_BIT_A       0
// Bit positions of the stretch and interrupt control registers.
`define CPCIR_BIT_ECLK_STRETCH_EN    0
`define CPCIR_BIT_EDGE    7
`define CPCIR_BIT_CONN    6
// Writable masks and reset values.
`define CPCIR_PULL_MASK   8'h93
`define CPCIR_DRIVE_MASK  8'h93
`define CPCIR_PULL_RST    8'h90
`define CPCIR_DRIVE_RST   8'h00
`define CPCIR_EXTINT_RST  8'h40
`define CPCIR_ZERO8       8'h00
// Port E pins 7 and 4:0 follow the pull bit; 5 and 6 pull only in reset.
`define CPCIR_PE_PULL_MSK 8'h9F
`define CPCIR_PE_RST_MSK  8'h60
// Interrupt status bits.
`define CPCIR_IST_EDGE    0
`define CPCIR_IST_LEVEL   1
`define CPCIR_IST_W       2
`endif

//--- verilog/cpcir_core_port_config_irq_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "cpcir_regs.vh"
module cpcir_core_port_config_irq_regs (
  // Clock and reset.
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Register port.
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  output reg        o_ext_pass,
  // Operating mode.
  input  wire       i_mode_special,
  input  wire       i_mode_single_chip,
  input  wire       i_mode_expanded,
  // Port direction, one bit per pin, high for output.
  input  wire [7:0] i_dir_a,
  input  wire [7:0] i_dir_b,
  input  wire [7:0] i_dir_e,
  input  wire [7:0] i_dir_k,
  // Pull enables per pin.
  output reg  [7:0] o_pull_a,
  output reg  [7:0] o_pull_b,
  output reg  [7:0] o_pull_e,
  output reg  [7:0] o_pull_k,
  // Reduced drive per port.
  output reg  [3:0] o_weak_drive,
  // E clock stretch.
  output reg        o_eclk_stretch,
  // External interrupt pin and service.
  input  wire       i_int_pin_n,
  input  wire       i_int_service,
  output reg        o_ext_int_req,
  // Block interrupt.
  output reg        o_irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] pull_enable_ctrl_reg;
  reg [7:0] drive_strength_ctrl_reg;
  reg       eclk_stretch_en_reg;
  reg       stretch_written_reg;
  reg       int_pin_edge_select_reg;
  reg       edge_written_reg;
  reg       int_pin_connect_reg;
  reg       pin_prev_reg;
  reg       edge_latch_reg;
  reg [`CPCIR_IST_W-1:0] istat_reg;
  reg [`CPCIR_IST_W-1:0] imask_reg;
  reg [`CPCIR_IST_W-1:0] istat_next;
  reg [7:0] rdata_next;

  localparam [7:0] EXTINT_RST = `CPCIR_EXTINT_RST;

  wire in_map = ~i_mode_expanded;
  wire wr_ok  = i_wr & in_map;
  wire rd_ok  = i_rd & in_map;
  wire fall   = pin_prev_reg & ~i_int_pin_n;
  wire edge_set = int_pin_connect_reg & int_pin_edge_select_reg & fall;
  wire lvl_set  = int_pin_connect_reg & ~int_pin_edge_select_reg
                  & ~i_int_pin_n;
  wire stretch_wr = wr_ok && (i_addr == `CPCIR_OFS_STRETCH);
  wire extint_wr  = wr_ok && (i_addr == `CPCIR_OFS_EXTINT);
  wire istat_rd   = rd_ok && (i_addr == `CPCIR_OFS_ISTAT);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pull_enable_ctrl_reg    <= `CPCIR_PULL_RST;
      drive_strength_ctrl_reg <= `CPCIR_DRIVE_RST;
      eclk_stretch_en_reg     <= 1'b0;
      stretch_written_reg     <= 1'b0;
      int_pin_edge_select_reg <= 1'b0;
      edge_written_reg        <= 1'b0;
      int_pin_connect_reg     <= EXTINT_RST[`CPCIR_BIT_CONN];
      imask_reg               <= {`CPCIR_IST_W{1'b0}};
    end else begin
      if (wr_ok && (i_addr == `CPCIR_OFS_PULL)) begin
        pull_enable_ctrl_reg <= i_wdata & `CPCIR_PULL_MASK;
      end
      if (wr_ok && (i_addr == `CPCIR_OFS_DRIVE)) begin
        drive_strength_ctrl_reg <= i_wdata & `CPCIR_DRIVE_MASK;
      end
      if (stretch_wr && (i_mode_special || !stretch_written_reg)) begin
        eclk_stretch_en_reg <= i_wdata[`CPCIR_BIT_ECLK_STRETCH_EN];
        stretch_written_reg <= 1'b1;
      end
      if (extint_wr) begin
        int_pin_connect_reg <= i_wdata[`CPCIR_BIT_CONN];
        if (i_mode_special || !edge_written_reg) begin
          int_pin_edge_select_reg <= i_wdata[`CPCIR_BIT_EDGE];
          edge_written_reg        <= 1'b1;
        end
      end
      if (wr_ok && (i_addr == `CPCIR_OFS_IMASK)) begin
        imask_reg <= i_wdata[`CPCIR_IST_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // External interrupt pin
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_prev_reg   <= 1'b1;
      edge_latch_reg <= 1'b0;
      o_ext_int_req  <= 1'b0;
    end else begin
      pin_prev_reg <= i_int_pin_n;
      if (!int_pin_connect_reg) begin
        edge_latch_reg <= 1'b0;
      end else if (edge_set) begin
        edge_latch_reg <= 1'b1;
      end else if (i_int_service) begin
        edge_latch_reg <= 1'b0;
      end
      if (!int_pin_connect_reg) begin
        o_ext_int_req <= 1'b0;
      end else if (int_pin_edge_select_reg) begin
        o_ext_int_req <= edge_latch_reg | edge_set;
      end else begin
        o_ext_int_req <= ~i_int_pin_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // Block interrupt status
  // ----------------------------------------------------------------
  always @* begin
    istat_next = istat_reg;
    if (istat_rd) begin
      istat_next = {`CPCIR_IST_W{1'b0}};
    end
    if (edge_set) begin
      istat_next[`CPCIR_IST_EDGE] = 1'b1;
    end
    if (lvl_set) begin
      istat_next[`CPCIR_IST_LEVEL] = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      istat_reg <= {`CPCIR_IST_W{1'b0}};
      o_irq     <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      o_irq     <= |(istat_next & imask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = `CPCIR_ZERO8;
    if (i_addr == `CPCIR_OFS_PULL) begin
      rdata_next = pull_enable_ctrl_reg;
    end else if (i_addr == `CPCIR_OFS_DRIVE) begin
      rdata_next = drive_strength_ctrl_reg;
    end else if (i_addr == `CPCIR_OFS_STRETCH) begin
      rdata_next[`CPCIR_BIT_ECLK_STRETCH_EN] = eclk_stretch_en_reg;
    end else if (i_addr == `CPCIR_OFS_RSVD) begin
      rdata_next = `CPCIR_ZERO8;
    end else if (i_addr == `CPCIR_OFS_EXTINT) begin
      rdata_next[`CPCIR_BIT_EDGE] = int_pin_edge_select_reg;
      rdata_next[`CPCIR_BIT_CONN] = int_pin_connect_reg;
    end else if (i_addr == `CPCIR_OFS_ISTAT) begin
      rdata_next[`CPCIR_IST_W-1:0] = istat_reg;
    end else if (i_addr == `CPCIR_OFS_IMASK) begin
      rdata_next[`CPCIR_IST_W-1:0] = imask_reg;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata    <= `CPCIR_ZERO8;
      o_ext_pass <= 1'b0;
    end else begin
      o_rdata    <= rd_ok ? rdata_next : `CPCIR_ZERO8;
      o_ext_pass <= (i_rd | i_wr) & ~in_map;
    end
  end

  // ----------------------------------------------------------------
  // Pin controls
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pull_a       <= `CPCIR_ZERO8;
      o_pull_b       <= `CPCIR_ZERO8;
      o_pull_e       <= `CPCIR_PE_RST_MSK;
      o_pull_k       <= `CPCIR_ZERO8;
      o_weak_drive   <= 4'h0;
      o_eclk_stretch <= 1'b0;
    end else begin
      o_pull_k <= {8{pull_enable_ctrl_reg[`CPCIR_BIT_K]}} & ~i_dir_k;
      o_pull_e <= {8{pull_enable_ctrl_reg[`CPCIR_BIT_E]}} & ~i_dir_e
                  & `CPCIR_PE_PULL_MSK;
      o_pull_b <= {8{pull_enable_ctrl_reg[`CPCIR_BIT_B]}} & ~i_dir_b;
      o_pull_a <= {8{pull_enable_ctrl_reg[`CPCIR_BIT_A]}} & ~i_dir_a;
      o_weak_drive <= {drive_strength_ctrl_reg[`CPCIR_BIT_K],
                       drive_strength_ctrl_reg[`CPCIR_BIT_E],
                       drive_strength_ctrl_reg[`CPCIR_BIT_B],
                       drive_strength_ctrl_reg[`CPCIR_BIT_A]};
      o_eclk_stretch <= eclk_stretch_en_reg & ~i_mode_single_chip;
    end
  end

endmodule
`default_nettype wire

//--- test/cpcir_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpcir_regs.vh"
module cpcir_checker (
  // Watched ports.
  input wire       i_clk,
  input wire       i_rst_n,
  input wire [3:0] i_addr,
  input wire       i_wr,
  input wire       i_rd,
  input wire       i_mode_expanded,
  input wire       i_mode_single_chip,
  input wire       i_int_pin_n,
  input wire [7:0] i_dir_a,
  input wire [7:0] i_dir_b,
  input wire [7:0] i_dir_e,
  input wire [7:0] i_dir_k,
  input wire [7:0] o_rdata,
  input wire [7:0] o_pull_a,
  input wire [7:0] o_pull_b,
  input wire [7:0] o_pull_e,
  input wire [7:0] o_pull_k,
  input wire [3:0] o_weak_drive,
  input wire       o_ext_pass,
  input wire       o_eclk_stretch,
  input wire       o_ext_int_req
);
  wire drv_wr;
  assign drv_wr = i_wr && i_addr == `CPCIR_OFS_DRIVE && !i_mode_expanded;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_pull_out_off: assert property ($past(i_rst_n) |->
    ((o_pull_a & $past(i_dir_a)) | (o_pull_b & $past(i_dir_b)) |
    (o_pull_k & $past(i_dir_k)) | (o_pull_e & $past(i_dir_e))) == 8'h00)
    else $error("pull on an output pin");
  a_pe_reset_only: assert property ($past(i_rst_n) |->
    o_pull_e[6:5] == 2'b00) else $error("port E pin 5 or 6 pulled");
  a_rsvd_zero: assert property (i_rd && !i_mode_expanded &&
    i_addr == `CPCIR_OFS_RSVD |=> o_rdata == 8'h00)
    else $error("reserved slot not zero");
  a_ext_pass_out: assert property ((i_wr || i_rd) && i_mode_expanded
    |=> o_ext_pass && o_rdata == 8'h00) else $error("no pass out");
  a_stretch_single: assert property (i_mode_single_chip |=>
    !o_eclk_stretch) else $error("stretch in single chip");
  a_req_after_low: assert property ($rose(o_ext_int_req) |->
    !$past(i_int_pin_n)) else $error("request without low pin");
  a_weak_after_write: assert property ($changed(o_weak_drive) |->
    $past(drv_wr, 2)) else $error("drive changed without write");
  a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data without read");
endmodule
bind cpcir_core_port_config_irq_regs cpcir_checker cpcir_checker_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .i_mode_expanded(i_mode_expanded),
  .i_mode_single_chip(i_mode_single_chip), .i_int_pin_n(i_int_pin_n),
  .i_dir_a(i_dir_a), .i_dir_b(i_dir_b), .i_dir_e(i_dir_e),
  .i_dir_k(i_dir_k), .o_rdata(o_rdata), .o_pull_a(o_pull_a),
  .o_pull_b(o_pull_b), .o_pull_e(o_pull_e), .o_pull_k(o_pull_k),
  .o_weak_drive(o_weak_drive), .o_ext_pass(o_ext_pass),
  .o_eclk_stretch(o_eclk_stretch), .o_ext_int_req(o_ext_int_req));
`default_nettype wire

//--- test/cpcir_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpcir_regs.vh"
module testbench;
  reg        i_clk, i_rst_n, i_wr, i_rd, i_int_pin_n, i_int_service;
  reg        i_mode_special, i_mode_single_chip, i_mode_expanded;
  reg  [3:0] i_addr;
  reg  [7:0] i_wdata;
  wire [7:0] o_rdata, o_pull_a, o_pull_b, o_pull_e, o_pull_k;
  wire [3:0] o_weak_drive;
  wire       o_ext_pass, o_eclk_stretch, o_ext_int_req, o_irq;
  integer    bad_count, samples_checked;
  cpcir_core_port_config_irq_regs cpcir_core_port_config_irq_regs_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ext_pass(o_ext_pass),
    .i_mode_special(i_mode_special), .i_mode_expanded(i_mode_expanded),
    .i_mode_single_chip(i_mode_single_chip), .i_dir_a(8'hF0),
    .i_dir_b(8'h00), .i_dir_e(8'h01), .i_dir_k(8'h0F),
    .o_pull_a(o_pull_a), .o_pull_b(o_pull_b), .o_pull_e(o_pull_e),
    .o_pull_k(o_pull_k), .o_weak_drive(o_weak_drive),
    .o_eclk_stretch(o_eclk_stretch), .i_int_pin_n(i_int_pin_n),
    .i_int_service(i_int_service), .o_ext_int_req(o_ext_int_req),
    .o_irq(o_irq));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 chk(o_rdata & m, e);
    end
  endtask
  task pin(input v);
    begin
      @(posedge i_clk);
      i_int_pin_n <= v;
      cyc(3);
    end
  endtask
  task rst;
    begin
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    bad_count = bad_count + 1;
    summarize;
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_int_service, i_addr, i_wdata} = 0;
    {i_mode_special, i_mode_single_chip, i_mode_expanded} = 3'b000;
    i_int_pin_n = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    rst;
    rd(`CPCIR_OFS_PULL, `CPCIR_PULL_RST, 8'hFF);
    cyc(1);
    chk(o_pull_k, 8'hF0);
    chk(o_pull_e, 8'h9E);
    wr(`CPCIR_OFS_PULL, 8'h93);
    cyc(2);
    chk(o_pull_a, 8'h0F);
    chk(o_pull_b, 8'hFF);
    wr(`CPCIR_OFS_PULL, 8'h00);
    cyc(2);
    chk(o_pull_k | o_pull_e | o_pull_b, 8'h00);
    wr(`CPCIR_OFS_DRIVE, 8'h93);
    cyc(2);
    chk({4'h0, o_weak_drive}, 8'h0F);
    wr(`CPCIR_OFS_DRIVE, 8'h82);
    rd(`CPCIR_OFS_DRIVE, 8'h82, 8'hFF);
    chk({4'h0, o_weak_drive}, 8'h0A);
    wr(`CPCIR_OFS_RSVD, 8'hFF);
    rd(`CPCIR_OFS_RSVD, 8'h00, 8'hFF);
    $display("pull and drive test done");
    wr(`CPCIR_OFS_STRETCH, 8'h01);
    wr(`CPCIR_OFS_STRETCH, 8'h00);
    rd(`CPCIR_OFS_STRETCH, 8'h01, 8'hFF);
    chk(o_eclk_stretch, 1'b1);
    i_mode_single_chip <= 1'b1;
    cyc(2);
    chk(o_eclk_stretch, 1'b0);
    i_mode_single_chip <= 1'b0;
    wr(`CPCIR_OFS_EXTINT, 8'hC0);
    wr(`CPCIR_OFS_EXTINT, 8'h00);
    rd(`CPCIR_OFS_EXTINT, 8'h80, 8'hFF);
    pin(1'b0);
    pin(1'b1);
    chk(o_ext_int_req, 1'b0);
    wr(`CPCIR_OFS_EXTINT, 8'h40);
    wr(`CPCIR_OFS_IMASK, 8'h01);
    rd(`CPCIR_OFS_EXTINT, 8'hC0, 8'hFF);
    pin(1'b0);
    pin(1'b1);
    chk(o_ext_int_req, 1'b1);
    chk(o_irq, 1'b1);
    rd(`CPCIR_OFS_ISTAT, 8'h01, 8'h01);
    @(posedge i_clk);
    i_int_service <= 1'b1;
    @(posedge i_clk);
    i_int_service <= 1'b0;
    cyc(2);
    chk({o_ext_int_req, o_irq}, 2'b00);
    $display("write once and edge test done");
    i_mode_expanded <= 1'b1;
    wr(`CPCIR_OFS_PULL, 8'hFF);
    #1 chk(o_ext_pass, 1'b1);
    i_mode_expanded <= 1'b0;
    rd(`CPCIR_OFS_PULL, 8'h00, 8'hFF);
    i_mode_special <= 1'b1;
    wr(`CPCIR_OFS_STRETCH, 8'h00);
    rd(`CPCIR_OFS_STRETCH, 8'h00, 8'hFF);
    i_mode_special <= 1'b0;
    rst;
    i_mode_special <= 1'b1;
    wr(`CPCIR_OFS_EXTINT, 8'hC0);
    wr(`CPCIR_OFS_EXTINT, 8'h40);
    rd(`CPCIR_OFS_EXTINT, 8'h40, 8'hFF);
    i_mode_special <= 1'b0;
    wr(`CPCIR_OFS_IMASK, 8'h02);
    pin(1'b0);
    chk(o_ext_int_req, 1'b1);
    chk(o_irq, 1'b1);
    pin(1'b1);
    chk(o_ext_int_req, 1'b0);
    rd(`CPCIR_OFS_ISTAT, 8'h02, 8'h02);
    chk(o_irq, 1'b0);
    $display("mode and level test done");
    summarize;
  end
endmodule
`default_nettype wire
